// File: src/ptm_timer_pair.sv
// Purpose: Two 16-bit timers, separate or cascaded into one 32-bit timer
// Assumes: clk is the instruction clock; pins are asynchronous to clk
// Notes:   Registers reached over AXI4-Lite; flags are sticky, write one to clear
`timescale 1ns/10ps
`default_nettype none
module ptm_timer_pair
   import ptm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // AXI4-Lite write address and data
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Device state and pins
   input  wire logic        idle_mode,
   input  wire logic        low_ext_clock_pin,
   input  wire logic        high_ext_clock_pin,
   // Events
   output logic             low_flag_pulse,
   output logic             high_flag_pulse,
   output logic             adc_trigger
);

   function automatic logic [7:0] ps_max(input logic [1:0] sel);
      unique case (sel)
         2'b00: ps_max = PS_MAX_1;
         2'b01: ps_max = PS_MAX_8;
         2'b10: ps_max = PS_MAX_64;
         2'b11: ps_max = PS_MAX_256;
      endcase
   endfunction : ps_max

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] v;
      v = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
      merge16 = v & mask;
   endfunction : merge16

   // Pin synchronisers
   logic [2:0]  sync_reg [2];
   logic [2:0]  sync_next [2];
   logic [1:0]  lvl_reg;
   logic [1:0]  lvl_next;
   logic [1:0]  pin_rise;
   logic [1:0]  pin_fall;

   // Timer state
   logic [15:0] ctrl_reg [2];
   logic [15:0] ctrl_next [2];
   logic [15:0] count_reg [2];
   logic [15:0] count_next [2];
   logic [15:0] period_reg [2];
   logic [15:0] period_next [2];
   logic [7:0]  pre_reg [2];
   logic [7:0]  pre_next [2];
   logic [1:0]  flag_reg;
   logic [1:0]  flag_next;
   logic [1:0]  flag_set;
   logic [1:0]  flag_clr;
   logic [1:0]  pulse_reg;
   logic        adc_reg;
   logic        adc_next;

   // Timer decode
   logic        casc;
   logic [15:0] cfg [2];
   logic [1:0]  run_eff;
   logic [1:0]  gate_en;
   logic [1:0]  src_tick;
   logic [1:0]  pre_hit;
   logic [1:0]  gate_fall;
   logic [31:0] cnt32;
   logic [31:0] per32;
   logic        wrap32;
   logic [1:0]  wrap16;
   logic        src;

   // Bus state
   logic        aw_got_reg, aw_got_next;
   logic        w_got_reg, w_got_next;
   logic [7:0]  awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0]  wstrb_reg, wstrb_next;
   logic        bvalid_reg, bvalid_next;
   logic [1:0]  bresp_reg, bresp_next;
   logic        rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0]  rresp_reg, rresp_next;
   logic        do_wr;
   logic [1:0]  wr_ctrl;
   logic [1:0]  wr_count;
   logic [1:0]  wr_period;

   assign s_axi_awready   = !aw_got_reg;
   assign s_axi_wready    = !w_got_reg;
   assign s_axi_arready   = !rvalid_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
   assign low_flag_pulse  = pulse_reg[FLAG_LO];
   assign high_flag_pulse = pulse_reg[FLAG_HI];
   assign adc_trigger     = adc_reg;

   // Synchronised pins; a change counts once stages two and three agree
   always_comb begin : sync_comb
      for (int i = 0; i < 2; i++) begin
         sync_next[i] = {sync_reg[i][1:0], (i == 0) ? low_ext_clock_pin : high_ext_clock_pin};
         lvl_next[i]  = (sync_reg[i][1] == sync_reg[i][2]) ? sync_reg[i][1] : lvl_reg[i];
         pin_rise[i]  = lvl_next[i] && !lvl_reg[i];
         pin_fall[i]  = !lvl_next[i] && lvl_reg[i];
      end
   end

   always_ff @(posedge clk) begin : sync_ff
      if (!rst_b) begin
         sync_reg[0] <= 3'h0;
         sync_reg[1] <= 3'h0;
         lvl_reg     <= 2'h0;
      end else begin
         sync_reg[0] <= sync_next[0];
         sync_reg[1] <= sync_next[1];
         lvl_reg     <= lvl_next;
      end
   end

   // Both sides of the bus; write address and data may arrive in either order
   always_comb begin : bus_comb
      aw_got_next = aw_got_reg;
      w_got_next  = w_got_reg;
      awaddr_next = awaddr_reg;
      wdata_next  = wdata_reg;
      wstrb_next  = wstrb_reg;
      bvalid_next = bvalid_reg && !s_axi_bready;
      bresp_next  = bresp_reg;
      rvalid_next = rvalid_reg && !s_axi_rready;
      rdata_next  = rdata_reg;
      rresp_next  = rresp_reg;
      if (s_axi_awvalid && !aw_got_reg) begin
         aw_got_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_reg) begin
         w_got_next = 1'b1;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      // Response waits until the previous one is accepted
      do_wr     = aw_got_reg && w_got_reg && !bvalid_reg;
      wr_ctrl   = '0;
      wr_count  = '0;
      wr_period = '0;
      flag_clr  = '0;
      if (do_wr) begin
         aw_got_next = 1'b0;
         w_got_next  = 1'b0;
         bvalid_next = 1'b1;
         bresp_next  = RESP_OKAY;
         unique case (awaddr_reg)
            ADDR_CTRL_LO:   wr_ctrl[0]   = 1'b1;
            ADDR_CTRL_HI:   wr_ctrl[1]   = 1'b1;
            ADDR_COUNT_LO:  wr_count[0]  = 1'b1;
            ADDR_COUNT_HI:  wr_count[1]  = 1'b1;
            ADDR_PERIOD_LO: wr_period[0] = 1'b1;
            ADDR_PERIOD_HI: wr_period[1] = 1'b1;
            ADDR_FLAGS:     flag_clr     = wstrb_reg[0] ? wdata_reg[1:0] : 2'h0;
            default:        bresp_next   = RESP_SLVERR;
         endcase
      end
      if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         unique case (s_axi_araddr)
            ADDR_CTRL_LO:   rdata_next = {16'h0, ctrl_reg[0]};
            ADDR_CTRL_HI:   rdata_next = {16'h0, ctrl_reg[1]};
            ADDR_COUNT_LO:  rdata_next = {16'h0, count_reg[0]};
            ADDR_COUNT_HI:  rdata_next = {16'h0, count_reg[1]};
            ADDR_PERIOD_LO: rdata_next = {16'h0, period_reg[0]};
            ADDR_PERIOD_HI: rdata_next = {16'h0, period_reg[1]};
            ADDR_FLAGS:     rdata_next = {30'h0, flag_reg};
            default: begin
               rdata_next = 32'h0;
               rresp_next = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin : bus_ff
      if (!rst_b) begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awaddr_reg <= 8'h0;
         wdata_reg  <= 32'h0;
         wstrb_reg  <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0;
         rresp_reg  <= RESP_OKAY;
      end else begin
         aw_got_reg <= aw_got_next;
         w_got_reg  <= w_got_next;
         awaddr_reg <= awaddr_next;
         wdata_reg  <= wdata_next;
         wstrb_reg  <= wstrb_next;
         bvalid_reg <= bvalid_next;
         bresp_reg  <= bresp_next;
         rvalid_reg <= rvalid_next;
         rdata_reg  <= rdata_next;
         rresp_reg  <= rresp_next;
      end
   end

   // Counting; a cascaded pair ignores the high control word except its stop-in-idle bit
   always_comb begin : timer_comb
      casc   = ctrl_reg[0][BIT_CASC];
      cnt32  = {count_reg[1], count_reg[0]};
      per32  = {period_reg[1], period_reg[0]};
      wrap16 = '0;
      for (int i = 0; i < 2; i++) begin
         cfg[i]       = casc ? ctrl_reg[0] : ctrl_reg[i];
         src          = casc ? 1'b0 : i[0];
         run_eff[i]   = cfg[i][BIT_RUN] &&
                        !(idle_mode && (ctrl_reg[i][BIT_SIDL] || (casc && ctrl_reg[1 - i][BIT_SIDL])));
         gate_en[i]   = cfg[i][BIT_GATE] && !cfg[i][BIT_CS];
         // Internal clock ticks every cycle, or only while the gate pin is high when gated; external counts synchronised rises
         src_tick[i]  = cfg[i][BIT_CS] ? pin_rise[src] : (!gate_en[i] || lvl_reg[src]);
         pre_hit[i]   = run_eff[i] && src_tick[i] && (pre_reg[i] == ps_max(cfg[i][BIT_PS_HI:BIT_PS_LO]));
         gate_fall[i] = gate_en[i] && run_eff[i] && pin_fall[src];
         if (wr_ctrl[i] || wr_count[i] || (casc && i == 1))
            pre_next[i] = PRE_RESET;
         else if (pre_hit[i])
            pre_next[i] = PRE_RESET;
         else if (run_eff[i] && src_tick[i])
            pre_next[i] = pre_reg[i] + 8'h01;
         else
            pre_next[i] = pre_reg[i];
         ctrl_next[i]   = wr_ctrl[i]
                        ? merge16(ctrl_reg[i], wdata_reg, wstrb_reg, (i == 0) ? CTRL_LO_MASK : CTRL_HI_MASK)
                        : ctrl_reg[i];
         period_next[i] = wr_period[i] ? merge16(period_reg[i], wdata_reg, wstrb_reg, 16'hffff) : period_reg[i];
      end
      wrap32 = casc && pre_hit[0] && (cnt32 == per32);
      if (casc) begin
         // Match clears the whole pair on the next tick
         if (pre_hit[0]) begin
            count_next[1] = (cnt32 == per32) ? 16'h0 : cnt32[31:16] + {15'h0, &cnt32[15:0]};
            count_next[0] = (cnt32 == per32) ? 16'h0 : cnt32[15:0] + 16'h0001;
         end else begin
            count_next[1] = count_reg[1];
            count_next[0] = count_reg[0];
         end
         flag_set = {wrap32 || gate_fall[0], 1'b0};
      end else begin
         for (int i = 0; i < 2; i++) begin
            wrap16[i]     = pre_hit[i] && (count_reg[i] == period_reg[i]);
            count_next[i] = !pre_hit[i] ? count_reg[i] : wrap16[i] ? 16'h0 : count_reg[i] + 16'h0001;
         end
         flag_set = wrap16 | gate_fall;
      end
      // Software loads win over counting
      for (int i = 0; i < 2; i++)
         if (wr_count[i])
            count_next[i] = merge16(count_reg[i], wdata_reg, wstrb_reg, 16'hffff);
      flag_next = (flag_reg & ~flag_clr) | flag_set;
      adc_next  = wrap32;
   end

   always_ff @(posedge clk) begin : timer_ff
      if (!rst_b) begin
         for (int i = 0; i < 2; i++) begin
            ctrl_reg[i]   <= CTRL_RESET;
            count_reg[i]  <= COUNT_RESET;
            period_reg[i] <= PERIOD_RESET;
            pre_reg[i]    <= PRE_RESET;
         end
         flag_reg  <= 2'h0;
         pulse_reg <= 2'h0;
         adc_reg   <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ctrl_reg[i]   <= ctrl_next[i];
            count_reg[i]  <= count_next[i];
            period_reg[i] <= period_next[i];
            pre_reg[i]    <= pre_next[i];
         end
         flag_reg  <= flag_next;
         pulse_reg <= flag_set;
         adc_reg   <= adc_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence lo_match_s;
      !casc && pre_hit[0] && count_reg[0] == period_reg[0] && !wr_count[0];
   endsequence

   sequence pair_match_s;
      casc && pre_hit[0] && cnt32 == per32 && !wr_count[0] && !wr_count[1];
   endsequence

   wrap_clear_a: assert property (lo_match_s |=> count_reg[0] == 16'h0 && flag_reg[FLAG_LO] ##0 low_flag_pulse)
      else $error("Low timer did not clear and flag on match");
   pair_flag_a: assert property (pair_match_s |=> cnt32 == 32'h0 && high_flag_pulse && !low_flag_pulse && adc_trigger)
      else $error("Pair match not reported on high flag and trigger");
   adc_pair_a: assert property (adc_trigger |-> $past(casc) && $past(pre_hit[0]))
      else $error("Converter trigger without cascaded match");
   run_stop_a: assert property (!ctrl_reg[0][BIT_RUN] && !wr_count[0] |=> $stable(count_reg[0]))
      else $error("Low count moved while stopped");
   idle_halt_a: assert property (idle_mode && ctrl_reg[0][BIT_SIDL] && !wr_count[0] |=> $stable(count_reg[0]))
      else $error("Low count moved in Idle with stop bit set");
   hi_ignored_a: assert property (casc && !pre_hit[0] && !wr_count[1] |=> $stable(count_reg[1]))
      else $error("High count moved without low carry in cascade");
   ctrl_zero_a: assert property ((ctrl_reg[0] & ~CTRL_LO_MASK) == 16'h0 && (ctrl_reg[1] & ~CTRL_HI_MASK) == 16'h0)
      else $error("Unused control bits not zero");
   pre_range_a: assert property (pre_reg[0] <= ps_max(cfg[0][BIT_PS_HI:BIT_PS_LO]) || $past(wr_ctrl[0]))
      else $error("Prescaler beyond terminal count");
   ext_only_a: assert property (cfg[0][BIT_CS] && !pin_rise[0] |-> !pre_hit[0])
      else $error("External mode ticked without pin edge");
   gate_fall_a: assert property (!casc && gate_fall[0] |=> flag_reg[FLAG_LO] && low_flag_pulse)
      else $error("Gate falling edge did not flag");

endmodule : ptm_timer_pair
`default_nettype wire

// File: src/ptm_pkg.sv
// Purpose: Shared constants for the paired 16/32-bit timer block
// Assumes: AXI4-Lite register access, one word per register
// Notes:   Control words store only their implemented bits
package ptm_pkg;

   // Register byte addresses
   localparam logic [7:0]  ADDR_CTRL_LO   = 8'h00;
   localparam logic [7:0]  ADDR_CTRL_HI   = 8'h04;
   localparam logic [7:0]  ADDR_COUNT_LO  = 8'h08;
   localparam logic [7:0]  ADDR_COUNT_HI  = 8'h0c;
   localparam logic [7:0]  ADDR_PERIOD_LO = 8'h10;
   localparam logic [7:0]  ADDR_PERIOD_HI = 8'h14;
   localparam logic [7:0]  ADDR_FLAGS     = 8'h18;

   // Control field positions
   localparam int          BIT_RUN        = 15;
   localparam int          BIT_SIDL       = 13;
   localparam int          BIT_GATE       = 6;
   localparam int          BIT_PS_HI      = 5;
   localparam int          BIT_PS_LO      = 4;
   localparam int          BIT_CASC       = 3;
   localparam int          BIT_CS         = 1;

   // Flag positions
   localparam int          FLAG_LO        = 0;
   localparam int          FLAG_HI        = 1;

   // Implemented control bits and reset values
   localparam logic [15:0] CTRL_LO_MASK   = 16'ha07a;
   localparam logic [15:0] CTRL_HI_MASK   = 16'ha072;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [15:0] PERIOD_RESET   = 16'hffff;
   localparam logic [7:0]  PRE_RESET      = 8'h00;

   // Prescaler terminal counts (ratio minus one)
   localparam logic [7:0]  PS_MAX_1       = 8'h00;
   localparam logic [7:0]  PS_MAX_8       = 8'h07;
   localparam logic [7:0]  PS_MAX_64      = 8'h3f;
   localparam logic [7:0]  PS_MAX_256     = 8'hff;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;

endpackage : ptm_pkg

// File: testbench/ptm_pin_model.sv
// Purpose: Drives the external clock and gate pins of both halves
// Assumes: Pins change just after a clock edge
// Notes:   Levels held 3 cycles or more so the synchroniser sees them
`timescale 1ns/10ps
`default_nettype none
module ptm_pin_model (
   // Clock
   input  wire logic clk,
   // Pins
   output var logic  lo_pin,
   output var logic  hi_pin
);
   initial begin
      lo_pin = 1'b0;
      hi_pin = 1'b0;
   end

   // Hold one pin at a level for some cycles
   task automatic set(input logic sel, input logic v, input int cyc);
      @(posedge clk);
      if (sel) begin
         hi_pin <= v;
      end else begin
         lo_pin <= v;
      end
      repeat (cyc - 1) @(posedge clk);
   endtask : set

   // Rising edges; small gap is a prompt source, large a slow one
   task automatic edges(input logic sel, input int n, input int gap);
      repeat (n) begin
         set(sel, 1'b1, gap);
         set(sel, 1'b0, gap);
      end
   endtask : edges
endmodule : ptm_pin_model
`default_nettype wire

// File: testbench/test_ptm_timer_pair.sv
// Purpose: Self-checking bench for the paired timer
// Assumes: AXI4-Lite master tasks; pin model on the far side
// Notes:   Intervals between flag pulses are exact, latencies only bounded
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_ptm_timer_pair;
   import ptm_pkg::*;
   logic        clk, rst_b, idle_mode, lo_pin, hi_pin;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
   logic        low_flag_pulse, high_flag_pulse, adc_trigger;
   logic [31:0] seed;
   int          bad_count, checks_done, n_lo, n_adc;

   ptm_timer_pair u_dut (.clk(clk), .rst_b(rst_b),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .idle_mode(idle_mode),
      .low_ext_clock_pin(lo_pin), .high_ext_clock_pin(hi_pin), .low_flag_pulse(low_flag_pulse),
      .high_flag_pulse(high_flag_pulse), .adc_trigger(adc_trigger));
   ptm_pin_model u_pins (.clk(clk), .lo_pin(lo_pin), .hi_pin(hi_pin));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (low_flag_pulse === 1'b1) n_lo++;
      if (adc_trigger === 1'b1) n_adc++;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic int ratio(input logic [1:0] ps);
      return (ps == 2'b11) ? 256 : (ps == 2'b10) ? 64 : (ps == 2'b01) ? 8 : 1;
   endfunction : ratio

   function automatic logic [15:0] ctl(input logic run, sidl, gate, input logic [1:0] ps, input logic casc, cs);
      logic [15:0] c;
      c = 16'h0000;
      c[BIT_RUN] = run;
      c[BIT_SIDL] = sidl;
      c[BIT_GATE] = gate;
      c[BIT_PS_HI:BIT_PS_LO] = ps;
      c[BIT_CASC] = casc;
      c[BIT_CS] = cs;
      return c;
   endfunction : ctl

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         // Drop only on a real handshake, so a following call never meets a second assignment
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      last_resp = s_axi_bresp;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      d = s_axi_rdata[15:0];
      last_resp = s_axi_rresp;
   endtask : rd

   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      `CHK(d, e)
   endtask : chk_rd

   task automatic wait_pulse(input int hi, output int cyc);
      cyc = 0;
      do begin
         @(posedge clk);
         cyc++;
      end while ((hi ? high_flag_pulse : low_flag_pulse) !== 1'b1 && cyc < 20000);
      if (cyc >= 20000) bad_count++;
   endtask : wait_pulse

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   // Hang guard, well above the worst-case run of some 12k cycles
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      finish_test();
   end

   initial begin
      logic [15:0] d, d2, p;
      logic [7:0]  b;
      int          c, n;
      {rst_b, idle_mode, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      seed = 32'ha7cb01a8;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk_rd(ADDR_CTRL_LO, CTRL_RESET);
      chk_rd(ADDR_PERIOD_HI, PERIOD_RESET);
      chk_rd(8'h1c, 16'h0000);
      `CHK(last_resp, RESP_SLVERR)
      wr(8'h1c, 16'hffff);
      `CHK(last_resp, RESP_SLVERR)
      wr(ADDR_CTRL_HI, 16'hffff);
      `CHK(last_resp, RESP_OKAY)
      chk_rd(ADDR_CTRL_HI, CTRL_HI_MASK);
      wr(ADDR_CTRL_LO, 16'hffff);
      chk_rd(ADDR_CTRL_LO, CTRL_LO_MASK);
      wr(ADDR_CTRL_LO, 16'h0000);
      wr(ADDR_CTRL_HI, 16'h0000);
      // Each half alone at every prescale; pulse spacing is exact
      for (int side = 0; side < 2; side++) begin
         b = 8'(side * 4);
         for (int ps = 0; ps < 4; ps++) begin
            seed = lfsr(seed);
            p = {13'h0000, seed[2:0]} + 16'h0001;
            wr(ADDR_CTRL_LO + b, ctl(0, 0, 0, 2'(ps), 0, 0));
            wr(ADDR_COUNT_LO + b, 16'h0000);
            wr(ADDR_PERIOD_LO + b, p);
            wr(ADDR_CTRL_LO + b, ctl(1, 0, 0, 2'(ps), 0, 0));
            wait_pulse(side, c);
            wait_pulse(side, c);
            `CHK(c, (int'(p) + 1) * ratio(2'(ps)))
            wr(ADDR_CTRL_LO + b, 16'h0000);
         end
      end
      `CHK(n_adc, 0)
      chk_rd(ADDR_FLAGS, 16'h0003);
      wr(ADDR_FLAGS, 16'h0003);
      chk_rd(ADDR_FLAGS, 16'h0000);
      // Idle with and without stop-in-idle
      wr(ADDR_PERIOD_LO, 16'hffff);
      idle_mode <= 1'b1;
      wr(ADDR_CTRL_LO, ctl(1, 1, 0, 2'b00, 0, 0));
      rd(ADDR_COUNT_LO, d);
      rd(ADDR_COUNT_LO, d2);
      `CHK(d2, d)
      wr(ADDR_CTRL_LO, ctl(1, 0, 0, 2'b00, 0, 0));
      rd(ADDR_COUNT_LO, d);
      rd(ADDR_COUNT_LO, d2);
      `CHK(d2 > d, 1'b1)
      wr(ADDR_CTRL_LO, 16'h0000);
      // Cascade in Idle; high control holds settings that must be ignored
      n = n_lo;
      wr(ADDR_CTRL_HI, ctl(1, 0, 1, 2'b11, 0, 1));
      wr(ADDR_CTRL_LO, ctl(0, 0, 0, 2'b00, 1, 0));
      wr(ADDR_COUNT_HI, 16'h0000);
      wr(ADDR_COUNT_LO, 16'hfffe);
      seed = lfsr(seed);
      wr(ADDR_PERIOD_HI, 16'h0001);
      wr(ADDR_PERIOD_LO, {13'h0000, seed[2:0]});
      wr(ADDR_CTRL_LO, ctl(1, 0, 0, 2'b00, 1, 0));
      wait_pulse(1, c);
      `CHK(c < 16, 1'b1)
      // Event counters settle one edge after the pulse is seen
      wr(ADDR_CTRL_LO, 16'h0000);
      `CHK(n_adc, 1)
      `CHK(n_lo - n, 0)
      chk_rd(ADDR_COUNT_HI, 16'h0000);
      idle_mode <= 1'b0;
      wr(ADDR_CTRL_HI, 16'h0000);
      // External pin counting, gate bit set but ignored
      for (int side = 0; side < 2; side++) begin
         b = 8'(side * 4);
         seed = lfsr(seed);
         wr(ADDR_COUNT_LO + b, 16'h0000);
         wr(ADDR_PERIOD_LO + b, 16'hffff);
         wr(ADDR_CTRL_LO + b, ctl(1, 0, 1, 2'b00, 0, 1));
         u_pins.edges(side[0], int'(seed[2:0]) + 1, seed[3] ? 3 : 9);
         repeat (8) @(posedge clk);
         chk_rd(ADDR_COUNT_LO + b, {13'h0000, seed[2:0]} + 16'h0001);
         wr(ADDR_CTRL_LO + b, 16'h0000);
      end
      // Gated accumulation on the low half
      wr(ADDR_COUNT_LO, 16'h0000);
      wr(ADDR_CTRL_LO, ctl(1, 0, 1, 2'b00, 0, 0));
      repeat (10) @(posedge clk);
      chk_rd(ADDR_COUNT_LO, 16'h0000);
      seed = lfsr(seed);
      n = 20 + int'(seed[4:0]);
      u_pins.set(1'b0, 1'b1, n);
      u_pins.set(1'b0, 1'b0, 1);
      wait_pulse(0, c);
      `CHK(c < 10, 1'b1)
      rd(ADDR_COUNT_LO, d);
      `CHK(int'(d) >= n - 1 && int'(d) <= n + 1, 1'b1)
      finish_test();
   end
endmodule : test_ptm_timer_pair
`default_nettype wire
